// ---- rtl/drs_pkg.sv ----
// Constants and types for the reset sources and power-up timer block
package drs_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 40;
   localparam int PLL_LOCK_NS = 2000000;
   // Least delay, so round up to whole cycles
   localparam int PLL_LOCK_CYC = (PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PIN_FILT_CYC = 4;
   localparam int BOR_MIN_CYC = 8;
   localparam logic [10:0] POWER_UP_TIMER_LAST = 11'h7FF;
   localparam logic [9:0] OST_LAST = 10'h3FF;

   // ----------------------------------------------------------------
   // Register map and fields
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_RESET_CONTROL_REG = 8'h00;
   localparam logic [7:0] OFS_STAT = 8'h04;
   localparam logic [7:0] OFS_CFG = 8'h08;
   localparam int RC_SBOR_BIT = 6;
   localparam int RC_POR_BIT = 1;
   localparam int RC_BOR_BIT = 0;
   localparam logic SBOR_RST = 1'b1;
   localparam logic POR_FLAG_RST = 1'b0;
   localparam logic BOR_FLAG_RST = 1'b0;
   localparam logic [7:0] CFG_RST = 8'h00;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      BOR_OFF = 2'h0,
      BOR_SW = 2'h1,
      BOR_NOSLP = 2'h2,
      BOR_ON = 2'h3
   } drs_bor_mode_t;

   typedef enum logic [2:0] {
      SQ_START, SQ_BOR, SQ_POWER_UP_TIMER, SQ_OST, SQ_PLL, SQ_RUN
   } drs_seq_t;

   typedef struct packed {
      logic pll_en_cfg;
      logic osc_xtal_cfg;
      logic ext_reset_pin_enable_cfg;
      logic power_up_timer_disable_n_cfg;
      logic [1:0] brownout_level_cfg;
      drs_bor_mode_t brownout_enable_cfg;
   } drs_cfg_t;

   typedef struct packed {
      logic pin_s1;
      logic pin_s2;
      logic vok_s1;
      logic vok_s2;
      logic vok_d;
      logic vlow_s1;
      logic vlow_s2;
      logic slp_s1;
      logic slp_s2;
      logic rc_s1;
      logic rc_s2;
      logic rc_d;
      logic osc_s1;
      logic osc_s2;
      logic osc_d;
      logic [7:0] cfg_s1;
      logic [7:0] cfg_s2;
      drs_cfg_t cfg;
      logic [7:0] filt_cnt;
      logic pin_rst;
      logic pin_data;
      logic [7:0] bor_cnt;
      drs_seq_t seq;
      logic [10:0] power_up_timer_cnt;
      logic [9:0] ost_cnt;
      logic [15:0] pll_cnt;
      logic por_flag;
      logic bor_flag;
      logic sbor;
      logic sys_rst_n;
      logic bor_en;
      logic ap_valid;
      logic ap_write;
      logic [7:0] ap_addr;
      logic [31:0] rdata;
      logic rdy;
      logic resp;
   } drs_regs_t;

endpackage : drs_pkg

// ---- rtl/drs_top.sv ----
// Reset sources, brown-out control and power-up timer with AHB-Lite registers
//
// Summary of operation
// - Device stays in reset while enabled reset pin is held low.
// - Short low glitches on the reset pin are filtered out.
// - Reset pin is input only; nothing inside drives it.
// - Pin enable off: pin causes no reset, reads as digital input.
// - Supply rising above power-on threshold restarts the whole sequence.
// - Power-on flag cleared on power-on, untouched by other resets.
// - Only software sets the power-on flag back to one.
// - Brown-out mode: off, software, hardware except Sleep, always on.
// - Active detector resets when supply stays low past minimum duration.
// - Brown-out reset holds until supply is back above threshold.
// - Enabled power-up timer starts when supply recovers, extends reset.
// - Supply drop during power-up timing returns to brown-out, restarts.
// - Brown-out and power-up timer enables are independent.
// - Software mode: software enable bit turns detector on and off.
// - Other modes: software enable bit has no effect, reads zero.
// - Threshold comes only from level configuration, not software.
// - Brown-out flag cleared by every brown-out and power-on reset.
// - Hardware-except-Sleep mode disables detector in Sleep only.
// - Power-up timer is 11 bits, 2048 slow oscillator ticks.
// - Device held in reset while power-up timer counts.
// - Power-up timer enabled when its configuration bit is low.
// - Crystal modes count 1024 oscillator cycles after power-up timer.
// - PLL enabled: fixed lock delay follows oscillator start-up.
//
// Local design decisions: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
module drs_top
   import drs_pkg::*;
#(
   parameter int PIN_FILT = PIN_FILT_CYC,
   parameter int BOR_MIN = BOR_MIN_CYC,
   parameter int PLL_CYC = PLL_LOCK_CYC
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic ext_reset_pin_n,
   input wire logic vdd_above_por,
   input wire logic vdd_below_bor,
   input wire logic sleep_mode,
   input wire logic internal_rc_clock,
   input wire logic osc_in,
   input wire logic [7:0] cfg_strap,
   output logic sys_reset_n,
   output logic ext_pin_data,
   output logic [1:0] brownout_level,
   output logic brownout_detect_en
);

   drs_regs_t r_ff;
   drs_regs_t nxt_r;

   logic por_evt;
   logic rc_tick;
   logic osc_tick;
   logic bor_act;
   logic bor_trip;
   logic wr_reset_control_reg;
   logic [31:0] reset_control_reg_view;

   // ----------------------------------------------------------------
   // Sequencing helpers
   // ----------------------------------------------------------------
   function automatic drs_seq_t after_power_up_timer(input drs_cfg_t c);
      if (c.osc_xtal_cfg) begin
         return SQ_OST;
      end
      if (c.pll_en_cfg) begin
         return SQ_PLL;
      end
      return SQ_RUN;
   endfunction : after_power_up_timer

   function automatic drs_seq_t after_bor(input drs_cfg_t c);
      // POWER_UP_TIMER only if its own bit asks for it, never implied by brown-out
      if (!c.power_up_timer_disable_n_cfg) begin
         return SQ_POWER_UP_TIMER;
      end
      return after_power_up_timer(c);
   endfunction : after_bor

   function automatic logic [31:0] reset_control_reg_word(input drs_regs_t s);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[RC_SBOR_BIT] = s.sbor & (s.cfg.brownout_enable_cfg == BOR_SW);
      w[RC_POR_BIT] = s.por_flag;
      w[RC_BOR_BIT] = s.bor_flag;
      return w;
   endfunction : reset_control_reg_word

   // ----------------------------------------------------------------
   // Event decode from registered state
   // ----------------------------------------------------------------
   assign por_evt = r_ff.vok_s2 & ~r_ff.vok_d;
   assign rc_tick = r_ff.rc_s2 & ~r_ff.rc_d;
   assign osc_tick = r_ff.osc_s2 & ~r_ff.osc_d;
   assign reset_control_reg_view = reset_control_reg_word(r_ff);
   assign wr_reset_control_reg = r_ff.ap_valid & r_ff.ap_write & (r_ff.ap_addr == OFS_RESET_CONTROL_REG);

   always_comb begin
      case (r_ff.cfg.brownout_enable_cfg)
         BOR_OFF: bor_act = 1'b0;
         BOR_SW: bor_act = r_ff.sbor;
         // off in Sleep, back on elsewhere
         BOR_NOSLP: bor_act = ~r_ff.slp_s2;
         BOR_ON: bor_act = 1'b1;
         default: bor_act = 1'b0;
      endcase
   end

   // low longer than the minimum duration trips
   assign bor_trip = bor_act & r_ff.vlow_s2 & (r_ff.bor_cnt >= 8'(BOR_MIN));

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      nxt_r = r_ff;

      // two-stage synchronisers on every pin input
      nxt_r.pin_s1 = ext_reset_pin_n;
      nxt_r.pin_s2 = r_ff.pin_s1;
      nxt_r.vok_s1 = vdd_above_por;
      nxt_r.vok_s2 = r_ff.vok_s1;
      nxt_r.vok_d = r_ff.vok_s2;
      nxt_r.vlow_s1 = vdd_below_bor;
      nxt_r.vlow_s2 = r_ff.vlow_s1;
      nxt_r.slp_s1 = sleep_mode;
      nxt_r.slp_s2 = r_ff.slp_s1;
      nxt_r.rc_s1 = internal_rc_clock;
      nxt_r.rc_s2 = r_ff.rc_s1;
      nxt_r.rc_d = r_ff.rc_s2;
      nxt_r.osc_s1 = osc_in;
      nxt_r.osc_s2 = r_ff.osc_s1;
      nxt_r.osc_d = r_ff.osc_s2;
      nxt_r.cfg_s1 = cfg_strap;
      nxt_r.cfg_s2 = r_ff.cfg_s1;

      // configuration is latched only while waiting for supply
      if (r_ff.seq == SQ_START) begin
         nxt_r.cfg = drs_cfg_t'(r_ff.cfg_s2);
      end

      // pin must stay low a minimum count before it resets
      if (!r_ff.pin_s2 && nxt_r.cfg.ext_reset_pin_enable_cfg) begin
         if (r_ff.filt_cnt < 8'(PIN_FILT)) begin
            nxt_r.filt_cnt = r_ff.filt_cnt + 8'h01;
         end
      end else begin
         nxt_r.filt_cnt = 8'h00;
      end
      // disabled pin never resets, becomes plain input
      nxt_r.pin_rst = nxt_r.cfg.ext_reset_pin_enable_cfg &
                      (nxt_r.filt_cnt >= 8'(PIN_FILT));
      nxt_r.pin_data = nxt_r.cfg.ext_reset_pin_enable_cfg ? 1'b0 : r_ff.pin_s2;

      // Saturating low-time counter of the brown-out comparator
      if (bor_act && r_ff.vlow_s2) begin
         if (r_ff.bor_cnt < 8'(BOR_MIN)) begin
            nxt_r.bor_cnt = r_ff.bor_cnt + 8'h01;
         end
      end else begin
         nxt_r.bor_cnt = 8'h00;
      end

      // Software write to the reset control register
      if (wr_reset_control_reg) begin
         nxt_r.sbor = hwdata[RC_SBOR_BIT];
         // the only path that sets the power-on flag
         nxt_r.por_flag = hwdata[RC_POR_BIT];
         nxt_r.bor_flag = hwdata[RC_BOR_BIT];
      end

      case (r_ff.seq)
         SQ_START: begin
            if (r_ff.vok_s2) begin
               if (bor_act && r_ff.vlow_s2) begin
                  nxt_r.seq = SQ_BOR;
               end else begin
                  nxt_r.seq = after_bor(nxt_r.cfg);
               end
            end
         end
         SQ_BOR: begin
            // hold until the supply is back above threshold
            if (!r_ff.vlow_s2) begin
               nxt_r.seq = after_bor(r_ff.cfg);
            end
         end
         SQ_POWER_UP_TIMER: begin
            // 11-bit count of slow oscillator ticks
            if (rc_tick) begin
               nxt_r.power_up_timer_cnt = r_ff.power_up_timer_cnt + 11'h001;
               if (r_ff.power_up_timer_cnt == POWER_UP_TIMER_LAST) begin
                  nxt_r.seq = after_power_up_timer(r_ff.cfg);
               end
            end
         end
         SQ_OST: begin
            if (osc_tick) begin
               nxt_r.ost_cnt = r_ff.ost_cnt + 10'h001;
               if (r_ff.ost_cnt == OST_LAST) begin
                  nxt_r.seq = r_ff.cfg.pll_en_cfg ? SQ_PLL : SQ_RUN;
               end
            end
         end
         SQ_PLL: begin
            // fixed lock delay in system clocks
            nxt_r.pll_cnt = r_ff.pll_cnt + 16'h0001;
            if (r_ff.pll_cnt == 16'(PLL_CYC - 1)) begin
               nxt_r.seq = SQ_RUN;
            end
         end
         SQ_RUN: begin
            nxt_r.seq = SQ_RUN;
         end
         default: begin
            nxt_r.seq = SQ_START;
         end
      endcase

      // brown-out during any later phase restarts all timers
      if (bor_trip && r_ff.seq != SQ_START) begin
         nxt_r.seq = SQ_BOR;
      end
      // brown-out reset clears its flag, winning over a write
      if (bor_trip) begin
         nxt_r.bor_flag = 1'b0;
      end

      // loss or return of supply restarts from the top
      if (!r_ff.vok_s2 || por_evt) begin
         nxt_r.seq = SQ_START;
      end
      if (por_evt) begin
         // power-on clears both flags; other resets leave it
         nxt_r.por_flag = 1'b0;
         nxt_r.bor_flag = 1'b0;
         nxt_r.sbor = SBOR_RST;
      end

      if (nxt_r.seq != SQ_POWER_UP_TIMER) begin
         nxt_r.power_up_timer_cnt = 11'h000;
      end
      if (nxt_r.seq != SQ_OST) begin
         nxt_r.ost_cnt = 10'h000;
      end
      if (nxt_r.seq != SQ_PLL) begin
         nxt_r.pll_cnt = 16'h0000;
      end

      // reset held until the sequence runs and the pin is free
      nxt_r.sys_rst_n = (nxt_r.seq == SQ_RUN) & ~nxt_r.pin_rst;
      nxt_r.bor_en = bor_act;

      // AHB-Lite address phase; zero wait states, always OKAY
      nxt_r.ap_valid = hsel & htrans[1] & hready;
      nxt_r.ap_write = hwrite;
      nxt_r.ap_addr = haddr[7:0];
      nxt_r.rdy = 1'b1;
      nxt_r.resp = 1'b0;
      // Read data taken from next state so a write just before is seen
      nxt_r.rdata = 32'h0000_0000;
      if (hsel && htrans[1] && hready && !hwrite) begin
         case (haddr[7:0])
            OFS_RESET_CONTROL_REG: nxt_r.rdata = reset_control_reg_word(nxt_r);
            OFS_STAT: nxt_r.rdata = {27'h0, nxt_r.seq, nxt_r.bor_en, nxt_r.sys_rst_n};
            OFS_CFG: nxt_r.rdata = {24'h0, nxt_r.cfg};
            default: nxt_r.rdata = 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r_ff <= '0;
         r_ff.cfg <= drs_cfg_t'(CFG_RST);
         // Pin idles high on its pull-up; a low reset value would fake a press
         r_ff.pin_s1 <= 1'b1;
         r_ff.pin_s2 <= 1'b1;
         r_ff.seq <= SQ_START;
         r_ff.por_flag <= POR_FLAG_RST;
         r_ff.bor_flag <= BOR_FLAG_RST;
         r_ff.sbor <= SBOR_RST;
         r_ff.rdy <= 1'b1;
      end else begin
         r_ff <= nxt_r;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // no output reaches the reset pin; it is sampled only
   assign sys_reset_n = r_ff.sys_rst_n;
   assign ext_pin_data = r_ff.pin_data;
   assign brownout_level = r_ff.cfg.brownout_level_cfg;
   assign brownout_detect_en = r_ff.bor_en;
   assign hrdata = r_ff.rdata;
   assign hreadyout = r_ff.rdy;
   assign hresp = r_ff.resp;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   a_pin_holds_reset: assert property (r_ff.pin_rst |-> !sys_reset_n)
      else $error("pin reset not holding device");
   a_glitch_filtered: assert property (
      $rose(r_ff.pin_rst) |-> $past(r_ff.filt_cnt) == 8'(PIN_FILT - 1))
      else $error("pin reset without full low width");
   a_pin_disabled: assert property (
      !r_ff.cfg.ext_reset_pin_enable_cfg |-> !r_ff.pin_rst)
      else $error("disabled pin caused reset");
   a_por_clears_flags: assert property (
      por_evt |=> !r_ff.por_flag && !r_ff.bor_flag)
      else $error("power-on did not clear flags");
   a_por_no_hw_set: assert property (
      $rose(r_ff.por_flag) |-> $past(wr_reset_control_reg && hwdata[RC_POR_BIT]))
      else $error("power-on flag set without write");
   a_sbor_masked: assert property (
      r_ff.cfg.brownout_enable_cfg != BOR_SW |-> !reset_control_reg_view[RC_SBOR_BIT] && !bor_act ||
      r_ff.cfg.brownout_enable_cfg != BOR_OFF && !reset_control_reg_view[RC_SBOR_BIT])
      else $error("software enable visible outside software mode");
   a_sleep_disables: assert property (
      r_ff.cfg.brownout_enable_cfg == BOR_NOSLP && r_ff.slp_s2 |-> !bor_act)
      else $error("detector active in sleep");
   a_bor_hold: assert property (
      r_ff.seq == SQ_BOR && r_ff.vlow_s2 && r_ff.vok_s2 && !por_evt
      |=> r_ff.seq == SQ_BOR)
      else $error("left brown-out while supply low");
   a_power_up_timer_restart: assert property (
      r_ff.seq == SQ_POWER_UP_TIMER && bor_trip && r_ff.vok_s2 && !por_evt
      |=> r_ff.seq == SQ_BOR && r_ff.power_up_timer_cnt == 11'h000)
      else $error("power-up timer not restarted by brown-out");
   a_timer_in_reset: assert property (r_ff.seq != SQ_RUN |-> !sys_reset_n)
      else $error("reset released before sequence end");
   a_power_up_timer_length: assert property (
      r_ff.seq == SQ_POWER_UP_TIMER && r_ff.power_up_timer_cnt == POWER_UP_TIMER_LAST && rc_tick && !bor_trip
      && r_ff.vok_s2 && !por_evt |=> r_ff.seq != SQ_POWER_UP_TIMER)
      else $error("power-up timer length wrong");

   c_run_reached: cover property (r_ff.seq == SQ_PLL ##1 r_ff.seq == SQ_RUN);
   c_bor_trip: cover property (r_ff.seq == SQ_POWER_UP_TIMER ##1 r_ff.seq == SQ_BOR);
   c_pin_reset: cover property (r_ff.seq == SQ_RUN && $rose(r_ff.pin_rst));
   c_por_write: cover property ($rose(r_ff.por_flag));

endmodule : drs_top

// ---- testbench/drs_supply_model.sv ----
// Model of the supply monitor, reset pin and slow clock sources around the block
`timescale 1ns/100ps
module drs_supply_model #(
   parameter int RC_HALF = 2,
   parameter int OSC_HALF = 2
) (
   input wire logic hclk,
   input wire logic supply_on,
   input wire logic supply_low,
   input wire logic pin_low,
   output logic internal_rc_clock,
   output logic osc_in,
   output logic vdd_above_por,
   output logic vdd_below_bor,
   output logic ext_reset_pin_n
);
   int rc_cnt = 0;
   int osc_cnt = 0;

   initial begin
      internal_rc_clock = 1'b0;
      osc_in = 1'b0;
   end

   // Both oscillators run free; their phase is unrelated to any command
   always @(posedge hclk) begin
      rc_cnt <= (rc_cnt + 1) % RC_HALF;
      osc_cnt <= (osc_cnt + 1) % OSC_HALF;
      if (rc_cnt == RC_HALF - 1) begin
         internal_rc_clock <= ~internal_rc_clock;
      end
      if (osc_cnt == OSC_HALF - 1) begin
         osc_in <= ~osc_in;
      end
   end

   // A supply under the power-on level is also under the brown-out level
   assign vdd_above_por = supply_on;
   assign vdd_below_bor = supply_low | ~supply_on;
   // Pin has a pull-up; only the bench pulls it low
   assign ext_reset_pin_n = ~pin_low;
endmodule : drs_supply_model

// ---- testbench/test_device_reset_sources_and_powerup_timer.sv ----
// Self-checking bench for the reset sources and power-up timer block
`timescale 1ns/100ps
module test_device_reset_sources_and_powerup_timer import drs_pkg::*;;
   localparam int RCP = 4;
   localparam int OSCP = 4;
   localparam int PLLC = 10;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout, hresp;
   logic supply_on = 1'b1, supply_low = 1'b0, pin_low = 1'b0, sleep_mode = 1'b0;
   logic [7:0] cfg_strap = 8'h21;
   logic rc_clk, osc_clk, vpor, brownout_threshold, pin_n;
   logic sys_reset_n, ext_pin_data, brownout_detect_en;
   logic [1:0] brownout_level;
   int miscompares = 0, checks_done = 0, n;
   logic [31:0] rd;
   logic lo;
   logic [1:0] lvl;
   logic [7:0] cfg;

   always #20 hclk = ~hclk;

   drs_top #(.PIN_FILT(PIN_FILT_CYC), .BOR_MIN(BOR_MIN_CYC), .PLL_CYC(PLLC)) dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_reset_pin_n(pin_n),
      .vdd_above_por(vpor), .vdd_below_bor(brownout_threshold), .sleep_mode(sleep_mode),
      .internal_rc_clock(rc_clk), .osc_in(osc_clk), .cfg_strap(cfg_strap),
      .sys_reset_n(sys_reset_n), .ext_pin_data(ext_pin_data),
      .brownout_level(brownout_level), .brownout_detect_en(brownout_detect_en)
   );

   drs_supply_model #(.RC_HALF(RCP / 2), .OSC_HALF(OSCP / 2)) far (
      .hclk(hclk), .supply_on(supply_on), .supply_low(supply_low), .pin_low(pin_low),
      .internal_rc_clock(rc_clk), .osc_in(osc_clk), .vdd_above_por(vpor),
      .vdd_below_bor(brownout_threshold), .ext_reset_pin_n(pin_n)
   );

   // ----------------------------------------------------------------
   // Reporting
   // ----------------------------------------------------------------
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : test_done

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic cyc(input int k);
      repeat (k) @(posedge hclk);
   endtask : cyc

   // ----------------------------------------------------------------
   // Bus master
   // ----------------------------------------------------------------
   task automatic wait_rdy;
      int k;
      k = 0;
      do begin
         @(posedge hclk);
         k++;
      end while (hreadyout !== 1'b1 && k < 20);
      if (k >= 20) begin
         miscompares++;
         $display("BAD hready expected 1 seen timeout");
         test_done();
      end
   endtask : wait_rdy

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
   endtask : bus

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk("register read", rd, exp);
      chk("bus response", hresp, 0);
   endtask : rdchk

   // ----------------------------------------------------------------
   // Reset sequence helpers
   // ----------------------------------------------------------------
   function automatic int exp_delay(input logic [7:0] c);
      return (c[4] ? 0 : 2048 * RCP) + (c[6] ? 1024 * OSCP : 0) + (c[7] ? PLLC : 0);
   endfunction : exp_delay

   task automatic wait_rel(input int lim, output int k);
      k = 0;
      while (sys_reset_n !== 1'b1 && k < lim) begin
         @(posedge hclk);
         k++;
      end
      if (k >= lim) begin
         miscompares++;
         $display("BAD release expected 1 seen %b", sys_reset_n);
         test_done();
      end
   endtask : wait_rel

   // Slow clocks start at any phase, so allow a few ticks of slack below
   task automatic settle(input logic [7:0] c);
      int lim;
      lim = exp_delay(c);
      wait_rel(lim + 60, n);
      chk("release delay", n >= lim - 12, 1);
   endtask : settle

   task automatic power_up(input logic [7:0] c);
      supply_on <= 1'b0;
      cyc(4);
      cfg_strap <= c;
      cyc(4);
      supply_on <= 1'b1;
      settle(c);
   endtask : power_up

   task automatic watch(input int k);
      lo = 1'b0;
      repeat (k) begin
         @(posedge hclk);
         if (sys_reset_n !== 1'b1) lo = 1'b1;
      end
   endtask : watch

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(32'hdc30));
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      settle(8'h21);
      rdchk(OFS_RESET_CONTROL_REG, 32'h40);
      rdchk(OFS_STAT, 32'h17);
      bus(1'b1, OFS_CFG, $urandom);
      rdchk(OFS_CFG, 32'h21);
      bus(1'b1, 8'h0C, 32'hFFFFFFFF);
      rdchk(8'h0C, 32'h0);
      $display("test register reset values done");

      bus(1'b1, OFS_RESET_CONTROL_REG, 32'h43);
      cyc(50);
      rdchk(OFS_RESET_CONTROL_REG, 32'h43);
      bus(1'b1, OFS_RESET_CONTROL_REG, 32'h03);
      cyc(2);
      chk("detector disabled", brownout_detect_en, 0);
      supply_low <= 1'b1;
      watch(BOR_MIN_CYC + 20);
      supply_low <= 1'b0;
      chk("reset while disabled", lo, 0);
      bus(1'b1, OFS_RESET_CONTROL_REG, 32'h43);
      supply_low <= 1'b1;
      watch(200);
      chk("held in brown-out", sys_reset_n, 0);
      supply_low <= 1'b0;
      cyc(1000);
      chk("timer holds reset", sys_reset_n, 0);
      supply_low <= 1'b1;
      cyc(40);
      supply_low <= 1'b0;
      settle(8'h21);
      rdchk(OFS_RESET_CONTROL_REG, 32'h42);
      $display("test software brown-out done");

      pin_low <= 1'b1;
      cyc(PIN_FILT_CYC - 1);
      pin_low <= 1'b0;
      watch(20);
      chk("glitch ignored", lo, 0);
      pin_low <= 1'b1;
      watch(PIN_FILT_CYC + 6);
      chk("pin reset", sys_reset_n, 0);
      pin_low <= 1'b0;
      wait_rel(8, n);
      rdchk(OFS_RESET_CONTROL_REG, 32'h42);
      $display("test reset pin done");

      lvl = 2'($urandom_range(3, 0));
      cfg = {4'hD, lvl, 2'h3};
      power_up(cfg);
      rdchk(OFS_RESET_CONTROL_REG, 32'h0);
      bus(1'b1, OFS_RESET_CONTROL_REG, 32'h43);
      rdchk(OFS_RESET_CONTROL_REG, 32'h03);
      chk("threshold level", brownout_level, lvl);
      chk("detector on", brownout_detect_en, 1);
      pin_low <= 1'b1;
      watch(20);
      chk("pin ignored", lo, 0);
      chk("pin data low", ext_pin_data, 0);
      pin_low <= 1'b0;
      cyc(5);
      chk("pin data high", ext_pin_data, 1);
      supply_low <= 1'b1;
      watch(30);
      supply_low <= 1'b0;
      chk("always-on trip", lo, 1);
      settle(cfg);
      rdchk(OFS_RESET_CONTROL_REG, 32'h02);
      $display("test crystal start-up done");

      for (int m = 0; m < 4; m++) begin
         power_up({4'h3, 2'h0, 2'(m)});
         rdchk(OFS_RESET_CONTROL_REG, (m == 1) ? 32'h40 : 32'h0);
         sleep_mode <= 1'b1;
         cyc(6);
         chk("detector in sleep", brownout_detect_en, m == 1 || m == 3);
         sleep_mode <= 1'b0;
         cyc(6);
         chk("detector awake", brownout_detect_en, m != 0);
      end
      $display("test brown-out modes done");
      test_done();
   end
endmodule : test_device_reset_sources_and_powerup_timer
